// ===== system_control_coprocessor.sv
`timescale 1ns/1ns
// Overview of operation
// - Numbers 0-6, 10, 17-22 and 25-29 read zero and ignore writes.
// - Number 7 holds enables for registers the read instruction may use.
// - Number 8 captures the faulting address of each address exception.
// - Number 12 selects status, interrupt control and shadow set control.
// - Number 12 select 3 maps each interrupt vector to a shadow set.
// - Number 13 records the code of the latest general exception.
// - Number 14 loads the program counter of the latest general exception.
// - Number 15 select 0 reads a fixed identification and revision value.
// - Number 15 select 1 holds the exception vector base address.
// - Number 16 selects 0 to 3 report fixed configuration words.
// - Keeps kernel, user or debug mode and the global interrupt enable.
// - Number 23 holds debug control and latest debug exception status.
// - Number 24 loads the program counter of the latest debug exception.
// - Number 30 loads the program counter of the latest error exception.
// - Number 31 is a plain scratchpad for the debug handler.
module system_control_coprocessor #(
    parameter logic [31:0] IDENT_VALUE = 32'h0001_0000 // Arbitrary value.
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Exception events from the core pipeline.
    input wire sccp_pkg::gen_exc_t gen_exc,
    input wire sccp_pkg::addr_exc_t addr_exc,
    input wire sccp_pkg::dbg_exc_t dbg_exc,
    input wire logic err_exc_valid,
    input wire logic [31:0] err_exc_pc,
    input wire logic exc_return,
    input wire logic debug_return,
    // Control outputs to the core.
    output sccp_pkg::mode_t op_mode,
    output logic int_enable,
    output logic timer_request,
    output logic [31:0] hw_register_access_enables,
    output logic [31:0] exception_vector_base,
    output logic [3:0] shadow_set,
    output logic irq
);
    logic take;
    logic wr_pend_reg;
    logic [8:0] widx_reg;
    logic [31:0] rdata_next;
    logic [31:0] status_reg, status_next;
    localparam int IRQ_W_C = sccp_pkg::IRQ_W;

    logic [31:0] irqctl_reg, shadowctl_reg, shadowmap_reg;
    logic [31:0] cause_reg, excpc_reg, badaddr_reg;
    logic [31:0] count_reg, compare_reg, hwena_reg, vbase_reg;
    logic [31:0] debug_reg, dbgpc_reg, errpc_reg, scratch_reg;
    logic [IRQ_W_C-1:0] irq_st_reg, irq_mask_reg, irq_ev;
    logic timer_hit;
    sccp_pkg::mode_t mode_next;

    // Merges written bits under a mask into the old value.
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nv, input logic [31:0] mask);
        return (old & ~mask) | (nv & mask);
    endfunction

    // True for register numbers with no implemented function.
    function automatic logic is_reserved(input logic [4:0] num);
        return (num < 5'h07) || (num == 5'h0a) ||
            (num >= 5'h11 && num <= 5'h16) || (num >= 5'h19 && num <= 5'h1d);
    endfunction

    // True when the pending data phase writes the given number and select.
    function automatic logic wr_hit(input logic [4:0] num,
        input logic [2:0] sel);
        return wr_pend_reg && (widx_reg == {1'b0, num, sel});
    endfunction

    assign take = hsel && hready && htrans[1];
    assign timer_hit = (count_reg == compare_reg);

    // Bus address phase capture and registered read data.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            widx_reg <= 9'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= take && hwrite;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take) begin
                widx_reg <= haddr[10:2];
            end
            if (take && !hwrite) begin
                hrdata <= rdata_next;
            end
        end
    end

    // Read multiplexer by register number and select.
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (haddr[10:2] == sccp_pkg::IDX_IRQ_STATUS) begin
            rdata_next = {27'h0000000, irq_st_reg};
        end else if (haddr[10:2] == sccp_pkg::IDX_IRQ_MASK) begin
            rdata_next = {27'h0000000, irq_mask_reg};
        end else if (!haddr[10] && !is_reserved(haddr[9:5])) begin
            case (haddr[9:5])
                sccp_pkg::NUM_HWENA: rdata_next = hwena_reg;
                sccp_pkg::NUM_BADADDR: rdata_next = badaddr_reg;
                sccp_pkg::NUM_COUNT: rdata_next = count_reg;
                sccp_pkg::NUM_COMPARE: rdata_next = compare_reg;
                sccp_pkg::NUM_STATUS: begin
                    case (haddr[4:2])
                        3'h0: rdata_next = status_reg;
                        sccp_pkg::SEL_IRQCTL: rdata_next = irqctl_reg;
                        sccp_pkg::SEL_SHADOWCTL: rdata_next = shadowctl_reg;
                        sccp_pkg::SEL_SHADOWMAP: rdata_next = shadowmap_reg;
                        default: rdata_next = 32'h0000_0000;
                    endcase
                end
                sccp_pkg::NUM_CAUSE: begin
                    rdata_next = cause_reg;
                    rdata_next[sccp_pkg::CAUSE_TI] = timer_request;
                end
                sccp_pkg::NUM_EXCPC: rdata_next = excpc_reg;
                sccp_pkg::NUM_IDENT: begin
                    if (haddr[4:2] == 3'h0) begin
                        rdata_next = IDENT_VALUE;
                    end else if (haddr[4:2] == sccp_pkg::SEL_VBASE) begin
                        rdata_next = vbase_reg;
                    end
                end
                sccp_pkg::NUM_CONFIG: begin
                    if (!haddr[4]) begin
                        rdata_next =
                            sccp_pkg::CONFIG_VAL[haddr[3:2]];
                    end
                end
                sccp_pkg::NUM_DEBUG: rdata_next = debug_reg;
                sccp_pkg::NUM_DBGPC: rdata_next = dbgpc_reg;
                sccp_pkg::NUM_ERRPC: rdata_next = errpc_reg;
                sccp_pkg::NUM_SCRATCH: rdata_next = scratch_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Status: software bits, then return and exception effects on levels.
    always_comb begin
        status_next = status_reg;
        if (wr_hit(sccp_pkg::NUM_STATUS, 3'h0)) begin
            status_next = merge(status_reg, hwdata, sccp_pkg::STATUS_WMASK);
        end
        if (exc_return) begin
            if (status_next[sccp_pkg::ST_ERL]) begin
                status_next[sccp_pkg::ST_ERL] = 1'b0;
            end else begin
                status_next[sccp_pkg::ST_EXL] = 1'b0;
            end
        end
        if (gen_exc.valid) begin
            status_next[sccp_pkg::ST_EXL] = 1'b1;
        end
        if (err_exc_valid) begin
            status_next[sccp_pkg::ST_ERL] = 1'b1;
        end
    end

    // Status, interrupt control and shadow set registers.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_reg <= sccp_pkg::STATUS_RESET;
            irqctl_reg <= 32'h0000_0000;
            shadowctl_reg <= 32'h0000_0000;
            shadowmap_reg <= 32'h0000_0000;
        end else begin
            status_reg <= status_next;
            if (wr_hit(sccp_pkg::NUM_STATUS, sccp_pkg::SEL_IRQCTL)) begin
                irqctl_reg <= merge(irqctl_reg, hwdata,
                    sccp_pkg::IRQCTL_WMASK);
            end
            if (wr_hit(sccp_pkg::NUM_STATUS, sccp_pkg::SEL_SHADOWMAP)) begin
                shadowmap_reg <= hwdata;
            end
            if (gen_exc.valid && gen_exc.code == sccp_pkg::CODE_INTERRUPT)
            begin
                shadowctl_reg[9:6] <= shadowctl_reg[3:0];
                shadowctl_reg[3:0] <= shadowmap_reg[gen_exc.vector*4 +: 4];
            end else if (exc_return) begin
                shadowctl_reg[3:0] <= shadowctl_reg[9:6];
            end else if (wr_hit(sccp_pkg::NUM_STATUS, sccp_pkg::SEL_SHADOWCTL))
            begin
                shadowctl_reg <= merge(shadowctl_reg, hwdata,
                    sccp_pkg::SHADOWCTL_WMASK);
            end
        end
    end

    // Exception capture registers; the hardware event wins over a write.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            badaddr_reg <= 32'h0000_0000;
            cause_reg <= 32'h0000_0000;
            excpc_reg <= 32'h0000_0000;
            errpc_reg <= 32'h0000_0000;
        end else begin
            if (addr_exc.valid) begin
                badaddr_reg <= addr_exc.addr;
            end
            if (gen_exc.valid) begin
                cause_reg[6:2] <= gen_exc.code;
                excpc_reg <= gen_exc.pc;
            end else begin
                if (wr_hit(sccp_pkg::NUM_CAUSE, 3'h0)) begin
                    cause_reg <= merge(cause_reg, hwdata,
                        sccp_pkg::CAUSE_WMASK);
                end
                if (wr_hit(sccp_pkg::NUM_EXCPC, 3'h0)) begin
                    excpc_reg <= hwdata;
                end
            end
            if (err_exc_valid) begin
                errpc_reg <= err_exc_pc;
            end else if (wr_hit(sccp_pkg::NUM_ERRPC, 3'h0)) begin
                errpc_reg <= hwdata;
            end
        end
    end

    // Debug control, debug return pc and scratchpad.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            debug_reg <= 32'h0000_0000;
            dbgpc_reg <= 32'h0000_0000;
            scratch_reg <= 32'h0000_0000;
        end else begin
            if (dbg_exc.valid) begin
                debug_reg[sccp_pkg::DBG_DM] <= 1'b1;
                debug_reg[5:0] <= dbg_exc.cause;
                dbgpc_reg <= dbg_exc.pc;
            end else begin
                if (debug_return) begin
                    debug_reg[sccp_pkg::DBG_DM] <= 1'b0;
                end else if (wr_hit(sccp_pkg::NUM_DEBUG, 3'h0)) begin
                    debug_reg <= merge(debug_reg, hwdata,
                        sccp_pkg::DEBUG_WMASK);
                end
                if (wr_hit(sccp_pkg::NUM_DBGPC, 3'h0)) begin
                    dbgpc_reg <= hwdata;
                end
            end
            if (wr_hit(sccp_pkg::NUM_SCRATCH, 3'h0)) begin
                scratch_reg <= hwdata;
            end
        end
    end

    // Access enables and vector base, copied to the core outputs one cycle later.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hwena_reg <= 32'h0000_0000;
            vbase_reg <= sccp_pkg::VBASE_RESET;
        end else begin
            if (wr_hit(sccp_pkg::NUM_HWENA, 3'h0)) begin
                hwena_reg <= merge(hwena_reg, hwdata,
                    sccp_pkg::HWENA_WMASK);
            end
            if (wr_hit(sccp_pkg::NUM_IDENT, sccp_pkg::SEL_VBASE)) begin
                vbase_reg <= merge(vbase_reg, hwdata,
                    sccp_pkg::VBASE_WMASK);
            end
        end
    end

    // Cycle counter, compare and timer request; the raise wins over a clear.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_reg <= 32'h0000_0000;
            compare_reg <= 32'hffff_ffff;
            timer_request <= 1'b0;
        end else begin
            if (wr_hit(sccp_pkg::NUM_COUNT, 3'h0)) begin
                count_reg <= hwdata;
            end else begin
                count_reg <= count_reg + 32'h0000_0001;
            end
            if (wr_hit(sccp_pkg::NUM_COMPARE, 3'h0)) begin
                compare_reg <= hwdata;
            end
            if (timer_hit) begin
                timer_request <= 1'b1;
            end else if (wr_hit(sccp_pkg::NUM_COMPARE, 3'h0)) begin
                timer_request <= 1'b0;
            end
        end
    end

    // Operating mode: debug first, then kernel while any level is held.
    always_comb begin
        if (debug_reg[sccp_pkg::DBG_DM]) begin
            mode_next = sccp_pkg::MODE_DEBUG;
        end else if (status_reg[sccp_pkg::ST_EXL] ||
            status_reg[sccp_pkg::ST_ERL] || !status_reg[sccp_pkg::ST_UM]) begin
            mode_next = sccp_pkg::MODE_KERNEL;
        end else begin
            mode_next = sccp_pkg::MODE_USER;
        end
    end

    // Core-facing outputs, each from a flip-flop.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            op_mode <= sccp_pkg::MODE_KERNEL;
            int_enable <= 1'b0;
            hw_register_access_enables <= 32'h0000_0000;
            exception_vector_base <= sccp_pkg::VBASE_RESET;
            shadow_set <= 4'h0;
        end else begin
            op_mode <= mode_next;
            int_enable <= status_reg[sccp_pkg::ST_IE] &&
                !status_reg[sccp_pkg::ST_EXL] && !status_reg[sccp_pkg::ST_ERL];
            hw_register_access_enables <= hwena_reg;
            exception_vector_base <= vbase_reg;
            shadow_set <= shadowctl_reg[3:0];
        end
    end

    // Event collection for the interrupt status.
    always_comb begin
        irq_ev = '0;
        irq_ev[sccp_pkg::IRQ_TIMER] = timer_hit;
        irq_ev[sccp_pkg::IRQ_GEN] = gen_exc.valid;
        irq_ev[sccp_pkg::IRQ_ADDR] = addr_exc.valid;
        irq_ev[sccp_pkg::IRQ_DEBUG] = dbg_exc.valid;
        irq_ev[sccp_pkg::IRQ_ERROR] = err_exc_valid;
    end

    // Sticky status with write-one-to-clear; a new event beats the clear.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_st_reg <= '0;
            irq_mask_reg <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_pend_reg && widx_reg == sccp_pkg::IDX_IRQ_STATUS) begin
                irq_st_reg <= (irq_st_reg & ~hwdata[IRQ_W_C-1:0]) | irq_ev;
            end else begin
                irq_st_reg <= irq_st_reg | irq_ev;
            end
            if (wr_pend_reg && widx_reg == sccp_pkg::IDX_IRQ_MASK) begin
                irq_mask_reg <= hwdata[IRQ_W_C-1:0];
            end
            irq <= |(irq_st_reg & irq_mask_reg);
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_excpc_capture: assert property (gen_exc.valid |=>
        excpc_reg == $past(gen_exc.pc)) else $error("return pc not loaded");
    a_badaddr_capture: assert property (addr_exc.valid |=>
        badaddr_reg == $past(addr_exc.addr)) else $error("bad address lost");
    a_cause_code: assert property (gen_exc.valid |=>
        cause_reg[6:2] == $past(gen_exc.code)) else $error("cause wrong");
    a_timer_raise: assert property (timer_hit |=>
        timer_request) else $error("timer request not raised");
    a_timer_clear: assert property (
        wr_hit(sccp_pkg::NUM_COMPARE, 3'h0) && !timer_hit |=> !timer_request)
        else $error("compare write did not clear");
    a_reserved_zero: assert property (
        take && !hwrite && !haddr[10] && is_reserved(haddr[9:5]) |=>
        hrdata == 32'h0000_0000) else $error("reserved read not zero");
    a_ident_value: assert property (
        take && !hwrite && haddr[10:2] == {1'b0, sccp_pkg::NUM_IDENT, 3'h0}
        |=> hrdata == IDENT_VALUE) else $error("ident value wrong");
    a_dbgpc_capture: assert property (dbg_exc.valid |=>
        dbgpc_reg == $past(dbg_exc.pc) ##1 op_mode == sccp_pkg::MODE_DEBUG)
        else $error("debug entry wrong");
    a_errpc_capture: assert property (
        err_exc_valid && !dbg_exc.valid && !debug_reg[sccp_pkg::DBG_DM] |=>
        errpc_reg == $past(err_exc_pc) ##1 op_mode == sccp_pkg::MODE_KERNEL)
        else $error("error entry wrong");
endmodule

// ===== sccp_pkg.sv
package sccp_pkg;
    // Register numbers of the coprocessor; byte address is num*32 + sel*4.
    localparam logic [4:0] NUM_HWENA = 5'h07;
    localparam logic [4:0] NUM_BADADDR = 5'h08;
    localparam logic [4:0] NUM_COUNT = 5'h09;
    localparam logic [4:0] NUM_COMPARE = 5'h0b;
    localparam logic [4:0] NUM_STATUS = 5'h0c;
    localparam logic [4:0] NUM_CAUSE = 5'h0d;
    localparam logic [4:0] NUM_EXCPC = 5'h0e;
    localparam logic [4:0] NUM_IDENT = 5'h0f;
    localparam logic [4:0] NUM_CONFIG = 5'h10;
    localparam logic [4:0] NUM_DEBUG = 5'h17;
    localparam logic [4:0] NUM_DBGPC = 5'h18;
    localparam logic [4:0] NUM_ERRPC = 5'h1e;
    localparam logic [4:0] NUM_SCRATCH = 5'h1f;
    // Selects under register numbers 12 and 15.
    localparam logic [2:0] SEL_IRQCTL = 3'h1;
    localparam logic [2:0] SEL_SHADOWCTL = 3'h2;
    localparam logic [2:0] SEL_SHADOWMAP = 3'h3;
    localparam logic [2:0] SEL_VBASE = 3'h1;
    // Word index of the interrupt status and mask page.
    localparam logic [8:0] IDX_IRQ_STATUS = 9'h100;
    localparam logic [8:0] IDX_IRQ_MASK = 9'h101;
    // Field positions.
    localparam int ST_IE = 0;
    localparam int ST_EXL = 1;
    localparam int ST_ERL = 2;
    localparam int ST_UM = 4;
    localparam int CAUSE_TI = 30;
    localparam int CAUSE_CODE_LSB = 2;
    localparam int DBG_DM = 30;
    localparam int SS_PREV_LSB = 6;
    localparam logic [4:0] CODE_INTERRUPT = 5'h00;
    // Writable masks and reset values.
    localparam logic [31:0] STATUS_WMASK = 32'h0000_0017;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0004;
    localparam logic [31:0] IRQCTL_WMASK = 32'h0000_03e0;
    localparam logic [31:0] SHADOWCTL_WMASK = 32'h0000_f3c0;
    localparam logic [31:0] CAUSE_WMASK = 32'h0000_0300;
    localparam logic [31:0] HWENA_WMASK = 32'h0000_000f;
    localparam logic [31:0] VBASE_WMASK = 32'h3fff_f000;
    localparam logic [31:0] VBASE_RESET = 32'h8000_0000;
    localparam logic [31:0] DEBUG_WMASK = 32'h00f0_0000;
    localparam logic [31:0] CONFIG_VAL [4] = '{32'h8000_0000,
        32'h8000_0000, 32'h8000_0000, 32'h0000_0004};
    // Interrupt status bits.
    localparam int IRQ_TIMER = 0;
    localparam int IRQ_GEN = 1;
    localparam int IRQ_ADDR = 2;
    localparam int IRQ_DEBUG = 3;
    localparam int IRQ_ERROR = 4;
    localparam int IRQ_W = 5;

    typedef enum logic [2:0] {
        MODE_KERNEL = 3'b001,
        MODE_USER = 3'b010,
        MODE_DEBUG = 3'b100
    } mode_t;

    typedef struct packed {
        logic valid;
        logic [4:0] code;
        logic [2:0] vector;
        logic [31:0] pc;
    } gen_exc_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } addr_exc_t;

    typedef struct packed {
        logic valid;
        logic [5:0] cause;
        logic [31:0] pc;
    } dbg_exc_t;
endpackage

// ===== core_event_model.sv
`timescale 1ns/1ns
// Stands in for the core pipeline and raises one-cycle exception events.
module core_event_model (
    // Clock.
    input wire logic sys_clk,
    // Events toward the coprocessor.
    output sccp_pkg::gen_exc_t gen_exc,
    output sccp_pkg::addr_exc_t addr_exc,
    output sccp_pkg::dbg_exc_t dbg_exc,
    output logic err_exc_valid,
    output logic [31:0] err_exc_pc,
    output logic exc_return,
    output logic debug_return
);
    // All events start idle.
    initial begin
        gen_exc = '0;
        addr_exc = '0;
        dbg_exc = '0;
        err_exc_valid = 1'b0;
        err_exc_pc = '0;
        exc_return = 1'b0;
        debug_return = 1'b0;
    end
    // Each pulse lasts one edge; payloads are then inverted so stale data
    // never looks live.
    task automatic gen(input logic [4:0] c, input logic [2:0] v,
                       input logic [31:0] pc);
        gen_exc <= '{1'b1, c, v, pc};
        @(posedge sys_clk);
        gen_exc <= '{1'b0, ~c, ~v, ~pc};
    endtask
    task automatic addr(input logic [31:0] a);
        addr_exc <= '{1'b1, a};
        @(posedge sys_clk);
        addr_exc <= '{1'b0, ~a};
    endtask
    task automatic dbg(input logic [5:0] c, input logic [31:0] pc);
        dbg_exc <= '{1'b1, c, pc};
        @(posedge sys_clk);
        dbg_exc <= '{1'b0, ~c, ~pc};
    endtask
    task automatic err(input logic [31:0] pc);
        err_exc_valid <= 1'b1;
        err_exc_pc <= pc;
        @(posedge sys_clk);
        err_exc_valid <= 1'b0;
        err_exc_pc <= ~pc;
    endtask
    task automatic ret(input logic dbg_ret);
        exc_return <= !dbg_ret;
        debug_return <= dbg_ret;
        @(posedge sys_clk);
        exc_return <= 1'b0;
        debug_return <= 1'b0;
    endtask
endmodule

// ===== system_control_coprocessor_tb_top.sv
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("MISMATCH %0t got %h expected %h", $time, got, exp); \
    end \
end
module system_control_coprocessor_tb_top;
    localparam logic [31:0] IDENT = 32'h0001_0000; // Arbitrary value.
    localparam logic [31:0] A_IST = 32'h0000_0400;
    localparam logic [31:0] A_IMK = 32'h0000_0404;
    logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, hwena, vbase, rd, c1;
    sccp_pkg::gen_exc_t gen_exc;
    sccp_pkg::addr_exc_t addr_exc;
    sccp_pkg::dbg_exc_t dbg_exc;
    sccp_pkg::mode_t op_mode;
    logic err_v, exc_ret, dbg_ret, int_enable, timer_request, irq;
    logic [31:0] err_pc;
    logic [3:0] shadow_set;
    logic sel_on = 1'b1;
    int errors = 0;
    int comparisons = 0;
    system_control_coprocessor #(.IDENT_VALUE(IDENT))
        system_control_coprocessor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .gen_exc(gen_exc), .addr_exc(addr_exc), .dbg_exc(dbg_exc),
        .err_exc_valid(err_v), .err_exc_pc(err_pc), .exc_return(exc_ret),
        .debug_return(dbg_ret), .op_mode(op_mode), .int_enable(int_enable),
        .timer_request(timer_request), .hw_register_access_enables(hwena),
        .exception_vector_base(vbase), .shadow_set(shadow_set), .irq(irq));
    core_event_model core_event_model_inst (.sys_clk(sys_clk),
        .gen_exc(gen_exc), .addr_exc(addr_exc), .dbg_exc(dbg_exc),
        .err_exc_valid(err_v), .err_exc_pc(err_pc), .exc_return(exc_ret),
        .debug_return(dbg_ret));
    // Byte address of a register number and select.
    function automatic logic [31:0] ra(input logic [4:0] n,
                                       input logic [2:0] s);
        return {22'h0, n, s, 2'b00};
    endfunction
    // One single AHB-Lite transfer; read data lands in rd.
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel <= sel_on;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHECK(rd & m, e)
    endtask
    // Lets registered outputs land before they are looked at.
    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic stop_test();
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Clock at 4 ns.
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Watchdog cuts a hang short.
    initial begin
        #40000;
        errors++;
        stop_test();
    end
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHECK(op_mode, sccp_pkg::MODE_KERNEL)
        `CHECK({int_enable, timer_request, irq, hresp}, 4'h0)
        `CHECK(vbase, sccp_pkg::VBASE_RESET)
        @(posedge sys_clk);
        rst_n <= 1'b1;
        chk(ra(sccp_pkg::NUM_STATUS, 0), '1,
            sccp_pkg::STATUS_RESET);
        bus(1'b1, ra(sccp_pkg::NUM_IDENT, 0), 32'h0);
        chk(ra(sccp_pkg::NUM_IDENT, 0), '1, IDENT);
        for (int n = 0; n < 32; n++) begin
            if (n <= 6 || n == 10 || (n >= 17 && n <= 22)
                || (n >= 25 && n <= 29)) begin
                bus(1'b1, ra(5'(n), 0), 32'hffff_ffff);
                chk(ra(5'(n), 0), '1, 32'h0);
            end
        end
        bus(1'b1, ra(sccp_pkg::NUM_HWENA, 0), 32'hffff_ffff);
        chk(ra(sccp_pkg::NUM_HWENA, 0), '1, sccp_pkg::HWENA_WMASK);
        `CHECK(hwena, sccp_pkg::HWENA_WMASK)
        bus(1'b1, ra(sccp_pkg::NUM_SCRATCH, 0), 32'ha5c3_0f96);
        // A transfer with the select low must leave the register alone.
        sel_on = 1'b0;
        bus(1'b1, ra(sccp_pkg::NUM_SCRATCH, 0), 32'h0000_1234);
        sel_on = 1'b1;
        chk(ra(sccp_pkg::NUM_SCRATCH, 0), '1,
            32'ha5c3_0f96);
        bus(1'b1, ra(sccp_pkg::NUM_IDENT, 1), 32'hffff_ffff);
        chk(ra(sccp_pkg::NUM_IDENT, 1), '1, 32'hbfff_f000);
        settle();
        `CHECK(vbase, 32'hbfff_f000)
        for (int s = 0; s < 4; s++) begin
            chk(ra(sccp_pkg::NUM_CONFIG, 3'(s)), '1,
                sccp_pkg::CONFIG_VAL[s]);
        end
        bus(1'b1, ra(sccp_pkg::NUM_STATUS, 1), 32'hffff_ffff);
        chk(ra(sccp_pkg::NUM_STATUS, 1), '1,
            sccp_pkg::IRQCTL_WMASK);
        core_event_model_inst.addr(32'h0000_0a10);
        settle();
        core_event_model_inst.addr(32'h0000_0b24);
        chk(ra(sccp_pkg::NUM_BADADDR, 0), '1,
            32'h0000_0b24);
        bus(1'b1, ra(sccp_pkg::NUM_STATUS, 0), 32'h0000_0011);
        settle();
        `CHECK({op_mode, int_enable}, {sccp_pkg::MODE_USER, 1'b1})
        core_event_model_inst.gen(5'h04, 3'h0, 32'h0000_1230);
        settle();
        `CHECK({op_mode, int_enable}, {sccp_pkg::MODE_KERNEL, 1'b0})
        chk(ra(sccp_pkg::NUM_CAUSE, 0), 32'h7c, 32'h10);
        chk(ra(sccp_pkg::NUM_EXCPC, 0), '1, 32'h0000_1230);
        chk(ra(sccp_pkg::NUM_STATUS, 0), 32'h17, 32'h13);
        core_event_model_inst.ret(1'b0);
        settle();
        `CHECK(op_mode, sccp_pkg::MODE_USER)
        bus(1'b1, ra(sccp_pkg::NUM_STATUS, 3), 32'h0000_0050);
        core_event_model_inst.gen(sccp_pkg::CODE_INTERRUPT, 3'h1, 32'h40);
        settle();
        `CHECK(shadow_set, 4'h5)
        core_event_model_inst.ret(1'b0);
        settle();
        `CHECK(shadow_set, 4'h0)
        core_event_model_inst.dbg(6'h01, 32'h0000_2460);
        settle();
        `CHECK(op_mode, sccp_pkg::MODE_DEBUG)
        chk(ra(sccp_pkg::NUM_DBGPC, 0), '1, 32'h0000_2460);
        chk(ra(sccp_pkg::NUM_DEBUG, 0), 32'h4000_0000,
            32'h4000_0000);
        core_event_model_inst.ret(1'b1);
        settle();
        `CHECK(op_mode, sccp_pkg::MODE_USER)
        chk(ra(sccp_pkg::NUM_DEBUG, 0), 32'h4000_0000, 32'h0);
        core_event_model_inst.err(32'h0000_3690);
        settle();
        `CHECK(op_mode, sccp_pkg::MODE_KERNEL)
        chk(ra(sccp_pkg::NUM_ERRPC, 0), '1, 32'h0000_3690);
        bus(1'b0, ra(sccp_pkg::NUM_COUNT, 0), 32'h0);
        c1 = rd;
        bus(1'b0, ra(sccp_pkg::NUM_COUNT, 0), 32'h0);
        `CHECK(rd - c1, 32'h2)
        bus(1'b1, ra(sccp_pkg::NUM_COMPARE, 0), rd + 32'd40);
        for (int i = 0; i < 100 && timer_request !== 1'b1; i++) settle();
        `CHECK(timer_request, 1'b1)
        chk(ra(sccp_pkg::NUM_CAUSE, 0), 32'h4000_0000,
            32'h4000_0000);
        bus(1'b1, ra(sccp_pkg::NUM_COMPARE, 0), 32'hffff_ffff);
        settle();
        `CHECK(timer_request, 1'b0)
        chk(A_IST, 32'h1f, 32'h1f);
        `CHECK(irq, 1'b0)
        bus(1'b1, A_IMK, 32'h0000_0004);
        settle();
        `CHECK(irq, 1'b1)
        bus(1'b1, A_IST, 32'h0000_0004);
        settle();
        `CHECK(irq, 1'b0)
        chk(A_IST, 32'h1f, 32'h1b);
        stop_test();
    end
endmodule
